// [design/cgs_pkg.sv]
// Package for the clock generator status block: offsets, fields, reset
// values and the clock mode encoding.
// Assumes an 8-bit register port with byte-wide offsets.
package cgs_pkg;

    // Register offsets
    localparam logic [7:0] OFF_STATUS_MAIN = 8'h00;
    localparam logic [7:0] OFF_STATUS_OSC  = 8'h01;
    localparam logic [7:0] OFF_MODE_CTRL   = 8'h02;
    localparam logic [7:0] OFF_LOSS_CTRL   = 8'h03;
    localparam logic [7:0] OFF_IRQ_STAT    = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'h05;

    // Main status field positions
    localparam int MODE_ST_HI = 7;
    localparam int MODE_ST_LO = 6;
    localparam int REF_ST_BIT = 5;
    localparam int LOL_BIT    = 4;
    localparam int LOCK_BIT   = 3;
    localparam int LOC_BIT    = 2;
    localparam int EXT_OK_BIT = 1;
    localparam int IRQF_BIT   = 0;

    // Oscillator status and control field positions
    localparam int OSC_ST_BIT  = 0;
    localparam int MODE_SEL_HI = 4;
    localparam int MODE_SEL_LO = 3;
    localparam int LOCK_LOSS_RESET_ENABLE_BIT   = 7;
    localparam int CLOCK_LOSS_RESET_ENABLE_BIT   = 3;

    // Event bits of the interrupt status register
    localparam int EV_IRQ_REQ  = 0;
    localparam int EV_RST_REQ  = 1;
    localparam int EV_OSC_UP   = 2;
    localparam int EV_MODE_CHG = 3;
    localparam int EV_W        = 4;

    // Reset values
    localparam logic [7:0]      MODE_CTRL_RST = 8'h00;
    localparam logic [7:0]      LOSS_CTRL_RST = 8'h00;
    localparam logic [EV_W-1:0] IRQ_MASK_RST  = 4'h0;

    // Stability check: tolerated count error change and samples needed
    localparam logic [7:0] UNLOCK_TOL     = 8'h02;
    localparam logic [1:0] STABLE_SAMPLES = 2'h2;

    // Clock modes, shared by select and status fields
    typedef enum logic [1:0] {
        CGS_SELF_CLOCKED = 2'h0,
        CGS_FLL_INT      = 2'h1,
        CGS_BYPASS_EXT   = 2'h2,
        CGS_FLL_EXT      = 2'h3
    } cgs_mode_t;

endpackage

// [design/cgs_sync2.sv]
// Two-stage carrier that moves the requested mode into the generator
// domain timing; the first stage is read only by the second.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module cgs_sync2 #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // Two flops back to back
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// [design/cgs_sticky.sv]
// One sticky flag: set by hardware, cleared by a clear pulse.
// Set wins over clear so an event in the clearing cycle is kept.
`timescale 1ns/1ps
module cgs_sticky (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Control
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule

// [design/cgs_status.sv]
// Clock generator status block: mode status, lock and loss flags,
// interrupt flag with its clear sequence, oscillator stability.
// Assumes one clock, inputs synchronous to it, a simple register port.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module cgs_status (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Clock generator status inputs
    input  wire logic       gen_off,
    input  wire logic       fll_locked,
    input  wire logic       lock_lost,
    input  wire logic       clock_lost,
    input  wire logic       crystal_selected,
    input  wire logic       ext_ref_ok,
    input  wire logic       osc_sample,
    input  wire logic [7:0] osc_count_err,
    input  wire logic       osc_toggling,
    // Outputs to the generator and system
    output logic      [1:0] clock_mode,
    output logic            osc_monitor_en,
    output logic            reset_req,
    output logic            irq
);

    // Mode sequencing states
    typedef enum logic [1:0] {
        CGS_ST_OFF,
        CGS_ST_WAIT,
        CGS_ST_RUN
    } cgs_state_t;

    cgs_state_t            state_q;
    logic [7:0]            mode_ctrl_q;
    logic [7:0]            loss_ctrl_q;
    logic [1:0]            mode_req_s;
    logic [1:0]            mode_q;
    logic [1:0]            mode_d;
    logic                  lock_q;
    logic                  ref_q;
    logic                  ext_ok_q;
    logic                  lol_flag;
    logic                  loc_flag;
    logic                  irqf_q;
    logic                  armed_q;
    logic                  osc_stable_q;
    logic [7:0]            prev_err_q;
    logic [1:0]            good_cnt_q;
    logic [7:0]            err_delta;
    logic                  sample_good;
    logic [cgs_pkg::EV_W-1:0] ev_stat_q;
    logic [cgs_pkg::EV_W-1:0] ev_mask_q;
    logic [cgs_pkg::EV_W-1:0] ev_set;
    logic [cgs_pkg::EV_W-1:0] ev_stat_d;
    logic                  wr_main;
    logic                  rd_main;
    logic                  irq_event;
    logic                  rst_event;
    logic                  clear_done;
    logic                  osc_was_q;
    logic [7:0]            status_main;
    logic                  fll_mode;

    // Register port decode
    assign wr_main = reg_wr && (reg_addr == cgs_pkg::OFF_STATUS_MAIN);
    assign rd_main = reg_rd && (reg_addr == cgs_pkg::OFF_STATUS_MAIN);

    // Control registers; mode select is a plain stored field
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_ctrl_q <= cgs_pkg::MODE_CTRL_RST;
            loss_ctrl_q <= cgs_pkg::LOSS_CTRL_RST;
        end else if (reg_wr) begin
            if (reg_addr == cgs_pkg::OFF_MODE_CTRL) begin
                mode_ctrl_q <= reg_wdata & 8'h18;
            end
            if (reg_addr == cgs_pkg::OFF_LOSS_CTRL) begin
                loss_ctrl_q <= reg_wdata & 8'h88;
            end
        end
    end

    // Requested mode crosses two stages before the sequencer sees it
    cgs_sync2 #(.W(2)) u_mode_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (mode_ctrl_q[cgs_pkg::MODE_SEL_HI:cgs_pkg::MODE_SEL_LO]),
        .q     (mode_req_s)
    );

    // Next mode: bypass waits for a good external reference
    always_comb begin
        mode_d = mode_q;
        if (mode_req_s == cgs_pkg::CGS_BYPASS_EXT) begin
            if (ext_ok_q) begin
                mode_d = mode_req_s;
            end
        end else begin
            mode_d = mode_req_s;
        end
    end

    // Mode sequencer; off holds self-clocked status
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= CGS_ST_RUN;
            mode_q  <= cgs_pkg::CGS_SELF_CLOCKED;
        end else begin
            unique case (state_q)
                CGS_ST_OFF: begin
                    mode_q <= cgs_pkg::CGS_SELF_CLOCKED;
                    if (!gen_off) begin
                        state_q <= mode_req_s[0] ? CGS_ST_WAIT : CGS_ST_RUN;
                    end
                end
                CGS_ST_WAIT: begin
                    // Stay self-clocked until the oscillator settles
                    if (gen_off) begin
                        state_q <= CGS_ST_OFF;
                    end else if (osc_stable_q) begin
                        state_q <= CGS_ST_RUN;
                        mode_q  <= mode_d;
                    end
                end
                CGS_ST_RUN: begin
                    if (gen_off) begin
                        state_q <= CGS_ST_OFF;
                        mode_q  <= cgs_pkg::CGS_SELF_CLOCKED;
                    end else begin
                        mode_q <= mode_d;
                    end
                end
                // An unused state code falls back to off, the safe place to restart
                default: begin
                    state_q <= CGS_ST_OFF;
                end
            endcase
        end
    end

    assign fll_mode = (mode_q == cgs_pkg::CGS_FLL_INT) ||
                      (mode_q == cgs_pkg::CGS_FLL_EXT);

    // Live status bits sampled from the generator
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lock_q   <= 1'b0;
            ref_q    <= 1'b0;
            ext_ok_q <= 1'b0;
        end else begin
            lock_q   <= fll_locked && fll_mode && (state_q == CGS_ST_RUN) && !gen_off;
            ref_q    <= crystal_selected;
            ext_ok_q <= ext_ref_ok;
        end
    end

    // Oscillator stability: change of count error between samples
    assign err_delta = (osc_count_err >= prev_err_q) ?
                       (osc_count_err - prev_err_q) : (prev_err_q - osc_count_err);
    assign sample_good = err_delta <= cgs_pkg::UNLOCK_TOL;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_err_q   <= 8'h00;
            good_cnt_q   <= 2'h0;
            osc_stable_q <= 1'b0;
        end else if (gen_off || !osc_toggling) begin
            // A static clock or the off state drops stability at once
            good_cnt_q   <= 2'h0;
            osc_stable_q <= 1'b0;
        end else if (osc_sample) begin
            prev_err_q <= osc_count_err;
            if (!sample_good) begin
                good_cnt_q   <= 2'h0;
                osc_stable_q <= 1'b0;
            end else if (good_cnt_q < cgs_pkg::STABLE_SAMPLES) begin
                good_cnt_q <= good_cnt_q + 2'h1;
                osc_stable_q <= (good_cnt_q + 2'h1) == cgs_pkg::STABLE_SAMPLES;
            end
        end
    end

    // Loss events pick interrupt or reset from their enables
    assign irq_event = (lock_lost && !loss_ctrl_q[cgs_pkg::LOCK_LOSS_RESET_ENABLE_BIT]) ||
                       (clock_lost && !loss_ctrl_q[cgs_pkg::CLOCK_LOSS_RESET_ENABLE_BIT]);
    assign rst_event = (lock_lost && loss_ctrl_q[cgs_pkg::LOCK_LOSS_RESET_ENABLE_BIT]) ||
                       (clock_lost && loss_ctrl_q[cgs_pkg::CLOCK_LOSS_RESET_ENABLE_BIT]);

    // Clear completes on a write of one after an armed read
    assign clear_done = wr_main && reg_wdata[cgs_pkg::IRQF_BIT] && armed_q;

    // Sticky loss flags, released by a completed clear sequence
    cgs_sticky u_lol (
        .clk   (clk),
        .rst_b (rst_b),
        .set   (lock_lost),
        .clr   (clear_done),
        .q     (lol_flag)
    );

    cgs_sticky u_loc (
        .clk   (clk),
        .rst_b (rst_b),
        .set   (clock_lost),
        .clr   (clear_done),
        .q     (loc_flag)
    );

    // Interrupt flag and its two-step clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqf_q  <= 1'b0;
            armed_q <= 1'b0;
        end else if (irq_event) begin
            irqf_q  <= 1'b1;
            armed_q <= 1'b0;
        end else if (clear_done) begin
            irqf_q  <= 1'b0;
            armed_q <= 1'b0;
        end else if (rd_main && irqf_q) begin
            armed_q <= 1'b1;
        end
    end

    // Reset request pulse towards the system
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reset_req <= 1'b0;
        end else begin
            reset_req <= rst_event;
        end
    end

    // Mode and monitor enable drive the generator from flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clock_mode     <= cgs_pkg::CGS_SELF_CLOCKED;
            osc_monitor_en <= 1'b0;
            osc_was_q      <= 1'b0;
        end else begin
            clock_mode     <= mode_q;
            osc_monitor_en <= (mode_q == cgs_pkg::CGS_SELF_CLOCKED) &&
                              osc_stable_q && !gen_off;
            osc_was_q      <= osc_stable_q;
        end
    end

    // Event sources for the system interrupt status
    always_comb begin
        ev_set = '0;
        ev_set[cgs_pkg::EV_IRQ_REQ]  = irq_event;
        ev_set[cgs_pkg::EV_RST_REQ]  = rst_event;
        ev_set[cgs_pkg::EV_OSC_UP]   = osc_stable_q && !osc_was_q;
        ev_set[cgs_pkg::EV_MODE_CHG] = mode_q != clock_mode;
    end

    // Read clears the status; an event in the same cycle survives
    always_comb begin
        ev_stat_d = ev_stat_q;
        if (reg_rd && (reg_addr == cgs_pkg::OFF_IRQ_STAT)) begin
            ev_stat_d = '0;
        end
        ev_stat_d = ev_stat_d | ev_set;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ev_stat_q <= '0;
            ev_mask_q <= cgs_pkg::IRQ_MASK_RST;
            irq       <= 1'b0;
        end else begin
            ev_stat_q <= ev_stat_d;
            if (reg_wr && (reg_addr == cgs_pkg::OFF_IRQ_MASK)) begin
                ev_mask_q <= reg_wdata[cgs_pkg::EV_W-1:0];
            end
            // Uses the next status so the level tracks without extra lag
            irq <= |(ev_stat_d & ev_mask_q);
        end
    end

    // Main status word; only the flag bit takes writes elsewhere
    always_comb begin
        status_main = 8'h00;
        status_main[cgs_pkg::MODE_ST_HI:cgs_pkg::MODE_ST_LO] = mode_q;
        status_main[cgs_pkg::REF_ST_BIT] = ref_q;
        status_main[cgs_pkg::LOL_BIT]    = lol_flag;
        // Gated by the shown mode: lock_q lags a mode switch by one cycle
        status_main[cgs_pkg::LOCK_BIT]   = lock_q && fll_mode;
        status_main[cgs_pkg::LOC_BIT]    = loc_flag;
        status_main[cgs_pkg::EXT_OK_BIT] = ext_ok_q;
        status_main[cgs_pkg::IRQF_BIT]   = irqf_q;
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                cgs_pkg::OFF_STATUS_MAIN: reg_rdata <= status_main;
                cgs_pkg::OFF_STATUS_OSC:  reg_rdata <= {7'h00, osc_stable_q};
                cgs_pkg::OFF_MODE_CTRL:   reg_rdata <= mode_ctrl_q;
                cgs_pkg::OFF_LOSS_CTRL:   reg_rdata <= loss_ctrl_q;
                cgs_pkg::OFF_IRQ_STAT:    reg_rdata <= {4'h0, ev_stat_q};
                cgs_pkg::OFF_IRQ_MASK:    reg_rdata <= {4'h0, ev_mask_q};
                default:                  reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// [dv/cgs_status_asserts.sv]
// Port-level checker for the clock generator status block.
// Assumes it is bound to cgs_status and sees only that module's ports.
`timescale 1ns/1ps
module cgs_status_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Generator side
    input wire logic       gen_off,
    input wire logic       lock_lost,
    input wire logic       clock_lost,
    input wire logic       crystal_selected,
    input wire logic       ext_ref_ok,
    input wire logic       reset_req
);
    logic lock_loss_reset_enable_q;
    logic clock_loss_reset_enable_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Shadow of the reset enables, so each request can be tied to its cause
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lock_loss_reset_enable_q <= 1'b0;
            clock_loss_reset_enable_q <= 1'b0;
        end else if (reg_wr && reg_addr == cgs_pkg::OFF_LOSS_CTRL) begin
            lock_loss_reset_enable_q <= reg_wdata[cgs_pkg::LOCK_LOSS_RESET_ENABLE_BIT];
            clock_loss_reset_enable_q <= reg_wdata[cgs_pkg::CLOCK_LOSS_RESET_ENABLE_BIT];
        end
    end

    // Reads of the two status registers
    sequence rd_main_s;
        reg_rd && reg_addr == cgs_pkg::OFF_STATUS_MAIN;
    endsequence
    sequence rd_osc_s;
        reg_rd && reg_addr == cgs_pkg::OFF_STATUS_OSC;
    endsequence
    // Inputs held stable, so a registered copy matches the live level
    sequence ref_held_s;
        $stable(crystal_selected) && $stable(ext_ref_ok);
    endsequence

    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    unmapped_rd_a: assert property (reg_rd && reg_addr > 8'h05 |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero data");
    ref_bit_a: assert property (
        rd_main_s ##0 ref_held_s |=> reg_rdata[5] == $past(crystal_selected, 2))
        else $error("reference status bit wrong");
    ext_ok_a: assert property (
        rd_main_s ##0 ref_held_s |=> reg_rdata[1] == $past(ext_ref_ok, 2))
        else $error("external reference status bit wrong");
    lock_forced_a: assert property (rd_main_s |=> !(reg_rdata[3] && !reg_rdata[6]))
        else $error("lock bit set outside a loop engaged mode");
    lol_reset_a: assert property (lock_lost && lock_loss_reset_enable_q |=> reset_req)
        else $error("no reset request after lock loss");
    loc_reset_a: assert property (clock_lost && clock_loss_reset_enable_q |=> reset_req)
        else $error("no reset request after clock loss");
    req_cause_a: assert property (
        reset_req |-> $past((lock_lost && lock_loss_reset_enable_q) || (clock_lost && clock_loss_reset_enable_q)))
        else $error("reset request without an enabled cause");
    osc_off_a: assert property (gen_off [*2] ##1 rd_osc_s |=> reg_rdata[0] == 1'b0)
        else $error("oscillator stable bit set while off");
    osc_ro_a: assert property (rd_osc_s |=> reg_rdata[7:1] == 7'h00)
        else $error("unused oscillator status bits nonzero");
endmodule

bind cgs_status cgs_status_asserts cgs_status_asserts_i (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gen_off(gen_off),
    .lock_lost(lock_lost), .clock_lost(clock_lost),
    .crystal_selected(crystal_selected), .ext_ref_ok(ext_ref_ok), .reset_req(reset_req)
);

// [dv/cgs_status_tb_top.sv]
// Self-checking bench for the clock generator status block.
// Assumes the block answers reads one cycle later and never stalls.
`timescale 1ns/1ps
module cgs_status_tb_top;
    logic       clk;
    logic       rst_b;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       gen_off;
    logic       fll_locked;
    logic       lock_lost;
    logic       clock_lost;
    logic       crystal_selected;
    logic       ext_ref_ok;
    logic       osc_sample;
    logic [7:0] osc_count_err;
    logic       osc_toggling;
    logic [1:0] clock_mode;
    logic       osc_monitor_en;
    logic       reset_req;
    logic       irq;
    logic [1:0] modes [4];
    logic [1:0] prev_mode;
    int         err_count = 0;
    int         num_checks = 0;
    int         cycles = 0;

    cgs_status cgs_status_i (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gen_off(gen_off),
        .fll_locked(fll_locked), .lock_lost(lock_lost), .clock_lost(clock_lost),
        .crystal_selected(crystal_selected), .ext_ref_ok(ext_ref_ok),
        .osc_sample(osc_sample), .osc_count_err(osc_count_err),
        .osc_toggling(osc_toggling), .clock_mode(clock_mode),
        .osc_monitor_en(osc_monitor_en), .reset_req(reset_req), .irq(irq)
    );

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Compare a register byte
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    // Compare a single output line
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t: line %b expected %b", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read strobe, then sample the answer in the following cycle only
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, exp);
    endtask

    // Loss event pulse: 0 for lock, 1 for clock; request must last one cycle
    task automatic pulse(input int w, input logic r);
        @(posedge clk);
        if (w == 0) lock_lost <= 1'b1;
        else clock_lost <= 1'b1;
        @(posedge clk);
        lock_lost <= 1'b0;
        clock_lost <= 1'b0;
        #1;
        chk1(reset_req, r);
        @(posedge clk);
        #1;
        chk1(reset_req, 1'b0);
    endtask

    task automatic osc(input logic [7:0] v);
        @(posedge clk);
        osc_sample <= 1'b1;
        osc_count_err <= v;
        @(posedge clk);
        osc_sample <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            $display("FAIL %0t: timeout", $time);
            complete_run();
        end
    end

    initial begin
        {rst_b, reg_wr, reg_rd, gen_off, fll_locked, lock_lost, clock_lost} = 7'h00;
        {crystal_selected, ext_ref_ok, osc_sample, osc_toggling} = 4'h0;
        {reg_addr, reg_wdata, osc_count_err} = 24'h00_0000;
        modes = '{2'h1, 2'h3, 2'h2, 2'h0};
        prev_mode = 2'h0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h00);
        rd_chk(cgs_pkg::OFF_STATUS_OSC, 8'h00);
        rd_chk(cgs_pkg::OFF_MODE_CTRL, cgs_pkg::MODE_CTRL_RST);
        rd_chk(cgs_pkg::OFF_LOSS_CTRL, cgs_pkg::LOSS_CTRL_RST);
        rd_chk(cgs_pkg::OFF_IRQ_MASK, {4'h0, cgs_pkg::IRQ_MASK_RST});
        rd_chk(8'h06, 8'h00);
        rd_chk(8'hFF, 8'h00);
        $display("test reset values done");
        // Static status bits, and writes that must not stick
        @(posedge clk);
        crystal_selected <= 1'b1;
        ext_ref_ok <= 1'b1;
        fll_locked <= 1'b1;
        idle(3);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h22);
        wr(cgs_pkg::OFF_STATUS_MAIN, 8'hFE);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h22);
        wr(cgs_pkg::OFF_STATUS_OSC, 8'h01);
        rd_chk(cgs_pkg::OFF_STATUS_OSC, 8'h00);
        $display("test static bits done");
        // Every mode; the clock_mode output must lag the request
        for (int i = 0; i < 4; i++) begin
            wr(cgs_pkg::OFF_MODE_CTRL, {3'h0, modes[i], 3'h0});
            chk8({6'h00, clock_mode}, {6'h00, prev_mode});
            idle(8);
            rd_chk(cgs_pkg::OFF_STATUS_MAIN, {modes[i], 2'b10, modes[i][0], 3'b010});
            chk8({6'h00, clock_mode}, {6'h00, modes[i]});
            prev_mode = modes[i];
        end
        rd_chk(cgs_pkg::OFF_IRQ_STAT, 8'h08);
        $display("test modes done");
        // Interrupt flag and its clear sequence
        wr(cgs_pkg::OFF_IRQ_MASK, 8'h01);
        pulse(0, 1'b0);
        idle(2);
        chk1(irq, 1'b1);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h33);
        wr(cgs_pkg::OFF_STATUS_MAIN, 8'h00);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h33);
        pulse(1, 1'b0);
        wr(cgs_pkg::OFF_STATUS_MAIN, 8'h01);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h37);
        wr(cgs_pkg::OFF_STATUS_MAIN, 8'h01);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h22);
        rd_chk(cgs_pkg::OFF_IRQ_STAT, 8'h01);
        idle(2);
        chk1(irq, 1'b0);
        wr(cgs_pkg::OFF_IRQ_MASK, 8'h00);
        pulse(0, 1'b0);
        idle(2);
        chk1(irq, 1'b0);
        rd_chk(cgs_pkg::OFF_IRQ_STAT, 8'h01);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h33);
        wr(cgs_pkg::OFF_STATUS_MAIN, 8'h01);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h22);
        $display("test interrupt flag done");
        // Reset requests instead of interrupts
        wr(cgs_pkg::OFF_LOSS_CTRL, 8'h88);
        rd_chk(cgs_pkg::OFF_LOSS_CTRL, 8'h88);
        pulse(0, 1'b1);
        pulse(1, 1'b1);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h36);
        rd_chk(cgs_pkg::OFF_IRQ_STAT, 8'h02);
        do_reset();
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h22);
        $display("test reset requests done");
        // Oscillator stability, off state, and the wait on leaving it
        @(posedge clk);
        osc_toggling <= 1'b1;
        osc(8'h05);
        osc(8'h06);
        idle(2);
        rd_chk(cgs_pkg::OFF_STATUS_OSC, 8'h00);
        chk1(osc_monitor_en, 1'b0);
        osc(8'h08);
        idle(2);
        rd_chk(cgs_pkg::OFF_STATUS_OSC, 8'h01);
        idle(2);
        chk1(osc_monitor_en, 1'b1);
        rd_chk(cgs_pkg::OFF_IRQ_STAT, 8'h04);
        @(posedge clk);
        gen_off <= 1'b1;
        idle(3);
        rd_chk(cgs_pkg::OFF_STATUS_OSC, 8'h00);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h22);
        wr(cgs_pkg::OFF_MODE_CTRL, 8'h08);
        idle(3); // Let the request cross both stages before leaving off
        gen_off <= 1'b0;
        idle(8);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h22);
        chk1(osc_monitor_en, 1'b0);
        repeat (3) osc(8'h01);
        idle(8);
        rd_chk(cgs_pkg::OFF_STATUS_MAIN, 8'h6A);
        $display("test oscillator done");
        complete_run();
    end
endmodule
